// ===== core/sbg_pkg.sv
`default_nettype none

package sbg_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_STATUS   = 8'h50;
    localparam logic [7:0] IDX_DATA     = 8'h51;
    localparam logic [7:0] IDX_BAUD     = 8'h52;
    localparam logic [7:0] IDX_CTRL_ONE = 8'h53;
    localparam logic [7:0] IDX_CTRL_TWO = 8'h54;
    localparam logic [7:0] IDX_RX_FINE  = 8'h55;
    localparam logic [7:0] IDX_TX_FINE  = 8'h57;

    // Reset values
    localparam logic [7:0] STATUS_RST   = 8'hc0;
    localparam logic [7:0] BAUD_RST     = 8'h00;
    localparam logic [7:0] CTRL_RST     = 8'h00;
    localparam logic [7:0] FINE_RST     = 8'h00;

    // Baud rate select field positions
    localparam int PRE_HI = 7;
    localparam int PRE_LO = 6;
    localparam int TXC_HI = 5;
    localparam int TXC_LO = 3;
    localparam int RXC_HI = 2;
    localparam int RXC_LO = 0;

    // Prescale factors per select code
    localparam logic [3:0] PRE_F0 = 4'h1;
    localparam logic [3:0] PRE_F1 = 4'h3;
    localparam logic [3:0] PRE_F2 = 4'h4;
    localparam logic [3:0] PRE_F3 = 4'hd;

    // Extended chain fixed stage
    localparam logic [3:0] SIXTEEN_LAST = 4'hf;

    // Status flags in register bit order 7..1, bit 0 reads zero
    typedef struct packed {
        logic tx_buffer_empty_flag;
        logic tx_complete;
        logic rx_data_ready_flag;
        logic rx_idle;
        logic rx_overrun;
        logic rx_noise;
        logic rx_framing;
    } sbg_status_t;

    // Event from the input shifter
    typedef struct packed {
        logic       push;
        logic       noise;
        logic       framing;
        logic       idle;
        logic [7:0] data;
    } sbg_rx_evt_t;

    // First prescale factor for a select code
    function automatic logic [3:0] first_prescale_factor(
        input logic [1:0] sel
    );
        case (sel)
            2'h0:    first_prescale_factor = PRE_F0;
            2'h1:    first_prescale_factor = PRE_F1;
            2'h2:    first_prescale_factor = PRE_F2;
            default: first_prescale_factor = PRE_F3;
        endcase
    endfunction : first_prescale_factor

    // Coarse factor is two to the field value, 1..128
    function automatic logic [7:0] coarse_factor(input logic [2:0] sel);
        coarse_factor = 8'h01 << sel;
    endfunction : coarse_factor

endpackage : sbg_pkg

`default_nettype wire

// ===== core/sbg_rate_chain.sv
`timescale 1ns/1ps
`default_nettype none

module sbg_rate_chain (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [1:0] prescale_sel,
    input  wire logic [2:0] coarse_sel,
    input  wire logic [7:0] fine_div,
    output logic            rate_tick
);
    import sbg_pkg::*;

    typedef struct packed {
        logic [3:0] pre_cnt;
        logic [3:0] sixteen_cnt;
        logic [7:0] stage_cnt;
        logic       tick;
    } sbg_chain_st_t;

    sbg_chain_st_t st_r;
    sbg_chain_st_t st_nxt;
    logic [3:0]    pre_lim;
    logic [7:0]    stage_lim;
    logic          ext_mode;
    logic          pre_tick;
    logic          stage_en;

    ////////////////////////////////////////////////////////////////////
    // Divider chain; >= compares keep a lowered divisor from locking up
    always_comb begin
        st_nxt    = st_r;
        st_nxt.tick = 1'b0;
        ext_mode  = (fine_div != FINE_RST);
        pre_lim   = first_prescale_factor(prescale_sel) - 4'h1;
        stage_lim = ext_mode ? fine_div - 8'h01
                             : coarse_factor(coarse_sel) - 8'h01;
        pre_tick  = (st_r.pre_cnt >= pre_lim);
        stage_en  = 1'b0;
        st_nxt.pre_cnt = pre_tick ? 4'h0 : st_r.pre_cnt + 4'h1;
        if (pre_tick) begin
            if (ext_mode) begin
                // Fixed divide-by-16 ahead of the fine stage
                st_nxt.sixteen_cnt = st_r.sixteen_cnt + 4'h1;
                stage_en = (st_r.sixteen_cnt == SIXTEEN_LAST);
            end else begin
                st_nxt.sixteen_cnt = 4'h0;
                stage_en = 1'b1;
            end
        end
        if (stage_en) begin
            if (st_r.stage_cnt >= stage_lim) begin
                st_nxt.stage_cnt = 8'h00;
                st_nxt.tick      = 1'b1;
            end else begin
                st_nxt.stage_cnt = st_r.stage_cnt + 8'h01;
            end
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rate_tick = st_r.tick;

endmodule : sbg_rate_chain

`default_nettype wire

// ===== core/sbg_top.sv
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Data location splits: writes fill transmit holding, reads return receive holding
// - Baud bits 7:6 pick first prescale 1, 3, 4 or 13
// - Baud bits 5:3 give transmit coarse factor, two to the power
// - Baud bits 2:0 give receive coarse factor, two to the power
// - Conventional transmit rate is clock over prescale times transmit factor
// - Conventional receive rate is clock over prescale times receive factor
// - Transmit coarse factor used only while transmit fine divider is zero
// - Receive coarse factor used only while receive fine divider is zero
// - Nonzero receive fine divider divides the divide-by-16 output by it
// - Nonzero transmit fine divider divides the divide-by-16 output by it
// - Reset clears both fine dividers, extended chains idle
// - Reset clears prescale select bits; divisor bits carry no promise
// - Status read then data write clears buffer-empty; no transfer while set
// - Status read then data read clears ready, idle, overrun, noise, framing
module sbg_top #(
    parameter int ADDR_W = 12
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    output logic      [7:0]        tx_holding_o,
    output logic                   tx_pending_o,
    input  wire logic              tx_take_i,
    input  wire logic              tx_done_i,
    input  wire sbg_pkg::sbg_rx_evt_t rx_evt_i,
    output logic      [7:0]        ctrl_one_o,
    output logic      [7:0]        ctrl_two_o,
    output logic                   tx_rate_tick_o,
    output logic                   rx_rate_tick_o
);
    import sbg_pkg::*;

    typedef struct packed {
        logic [31:0] rdata;
        logic        ack;
        logic        status_seen;
        sbg_status_t flags;
        logic [7:0]  tx_holding_reg;
        logic [7:0]  rx_holding_reg;
        logic [7:0]  baud_rate_select;
        logic [7:0]  ctrl_one;
        logic [7:0]  ctrl_two;
        logic [7:0]  rx_fine_divider;
        logic [7:0]  tx_fine_divider;
    } sbg_top_st_t;

    sbg_top_st_t st_r;
    sbg_top_st_t st_nxt;
    logic        req;
    logic        wr;
    logic        rd;
    logic [7:0]  idx;
    logic [7:0]  wbyte;
    logic [7:0]  rbyte;
    logic        clr_tx;
    logic        clr_rx;

    ////////////////////////////////////////////////////////////////////
    // Index of a word address
    function automatic logic [7:0] word_index(
        input logic [ADDR_W-1:0] adr
    );
        word_index = adr[9:2];
    endfunction : word_index

    // Status register image, bit 0 reads zero
    function automatic logic [7:0] status_byte(input sbg_status_t f);
        status_byte = {f, 1'b0};
    endfunction : status_byte

    ////////////////////////////////////////////////////////////////////
    // Bus decode, register file and data-path flags
    always_comb begin
        st_nxt = st_r;
        req    = wb_cyc_i && wb_stb_i && !st_r.ack;
        wr     = req && wb_we_i && wb_sel_i[0];
        rd     = req && !wb_we_i;
        idx    = word_index(wb_adr_i);
        wbyte  = wb_dat_i[7:0];
        clr_tx = 1'b0;
        clr_rx = 1'b0;
        rbyte  = 8'h00;

        // Classic single cycle: answer one cycle after the strobe
        st_nxt.ack = req;

        // Read mux; unmapped indices read zero
        case (idx)
            IDX_STATUS:   rbyte = status_byte(st_r.flags);
            IDX_DATA:     rbyte = st_r.rx_holding_reg;
            IDX_BAUD:     rbyte = st_r.baud_rate_select;
            IDX_CTRL_ONE: rbyte = st_r.ctrl_one;
            IDX_CTRL_TWO: rbyte = st_r.ctrl_two;
            IDX_RX_FINE:  rbyte = st_r.rx_fine_divider;
            IDX_TX_FINE:  rbyte = st_r.tx_fine_divider;
            default:      rbyte = 8'h00;
        endcase
        st_nxt.rdata = req ? {24'h000000, rbyte} : 32'h00000000;

        // Register writes
        if (wr) begin
            case (idx)
                IDX_DATA: begin
                    st_nxt.tx_holding_reg = wbyte;
                    clr_tx = st_r.status_seen;
                end
                IDX_BAUD:     st_nxt.baud_rate_select = wbyte;
                IDX_CTRL_ONE: st_nxt.ctrl_one         = wbyte;
                IDX_CTRL_TWO: st_nxt.ctrl_two         = wbyte;
                IDX_RX_FINE:  st_nxt.rx_fine_divider  = wbyte;
                IDX_TX_FINE:  st_nxt.tx_fine_divider  = wbyte;
                default: begin
                end
            endcase
        end

        // Status read arms the clear; a data access completes it
        if (rd && idx == IDX_STATUS) begin
            st_nxt.status_seen = 1'b1;
        end else if (req && idx == IDX_DATA) begin
            st_nxt.status_seen = 1'b0;
            clr_rx = rd && st_r.status_seen;
        end

        // Software clears first; hardware sets below win
        if (clr_tx) begin
            st_nxt.flags.tx_buffer_empty_flag = 1'b0;
            st_nxt.flags.tx_complete          = 1'b0;
        end
        if (clr_rx) begin
            st_nxt.flags.rx_data_ready_flag = 1'b0;
            st_nxt.flags.rx_idle            = 1'b0;
            st_nxt.flags.rx_overrun         = 1'b0;
            st_nxt.flags.rx_noise           = 1'b0;
            st_nxt.flags.rx_framing         = 1'b0;
        end

        // Shifter takes data only while the empty flag is clear
        if (tx_take_i && !st_r.flags.tx_buffer_empty_flag) begin
            st_nxt.flags.tx_buffer_empty_flag = 1'b1;
        end
        if (tx_done_i) begin
            st_nxt.flags.tx_complete = 1'b1;
        end

        // Received word: overrun keeps the held byte
        if (rx_evt_i.push) begin
            if (st_r.flags.rx_data_ready_flag) begin
                st_nxt.flags.rx_overrun = 1'b1;
            end else begin
                st_nxt.rx_holding_reg           = rx_evt_i.data;
                st_nxt.flags.rx_data_ready_flag = 1'b1;
                st_nxt.flags.rx_noise           = rx_evt_i.noise;
                st_nxt.flags.rx_framing         = rx_evt_i.framing;
            end
        end
        if (rx_evt_i.idle) begin
            st_nxt.flags.rx_idle = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r                  <= '0;
            st_r.flags            <= sbg_status_t'(STATUS_RST[7:1]);
            st_r.baud_rate_select <= BAUD_RST;
            st_r.ctrl_one         <= CTRL_RST;
            st_r.ctrl_two         <= CTRL_RST;
            st_r.rx_fine_divider  <= FINE_RST;
            st_r.tx_fine_divider  <= FINE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Separate transmit and receive rate chains
    sbg_rate_chain u_tx_chain (
        .clk          (clk),
        .rst          (rst),
        .prescale_sel (st_r.baud_rate_select[PRE_HI:PRE_LO]),
        .coarse_sel   (st_r.baud_rate_select[TXC_HI:TXC_LO]),
        .fine_div     (st_r.tx_fine_divider),
        .rate_tick    (tx_rate_tick_o)
    );

    sbg_rate_chain u_rx_chain (
        .clk          (clk),
        .rst          (rst),
        .prescale_sel (st_r.baud_rate_select[PRE_HI:PRE_LO]),
        .coarse_sel   (st_r.baud_rate_select[RXC_HI:RXC_LO]),
        .fine_div     (st_r.rx_fine_divider),
        .rate_tick    (rx_rate_tick_o)
    );

    // Outputs straight from state
    assign wb_dat_o     = st_r.rdata;
    assign wb_ack_o     = st_r.ack;
    assign tx_holding_o = st_r.tx_holding_reg;
    assign tx_pending_o = !st_r.flags.tx_buffer_empty_flag;
    assign ctrl_one_o   = st_r.ctrl_one;
    assign ctrl_two_o   = st_r.ctrl_two;

endmodule : sbg_top

`default_nettype wire

// ===== tb/sbg_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module sbg_assertions #(
    parameter int ADDR_W = 12
) (
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0]        wb_sel_i,
    input wire logic [31:0]       wb_dat_i,
    input wire logic [31:0]       wb_dat_o,
    input wire logic              wb_ack_o,
    input wire logic [7:0]        tx_holding_o,
    input wire logic              tx_pending_o,
    input wire logic              tx_take_i
);
    import sbg_pkg::*;
    logic dwr;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Taken data-register write
    assign dwr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i
        && wb_sel_i[0] && wb_adr_i[9:2] == IDX_DATA;
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_load;
        dwr ##1 tx_holding_o == $past(wb_dat_i[7:0]);
    endsequence
    ack_next_a: assert property (s_req |=> wb_ack_o)
        else $error("ack missing");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    hold_load_a: assert property (dwr |-> s_load)
        else $error("holding byte not loaded");
    hold_keep_a: assert property ($changed(tx_holding_o) |-> $past(dwr))
        else $error("holding byte changed alone");
    pend_keep_a: assert property (tx_pending_o && !tx_take_i |=> tx_pending_o)
        else $error("pending dropped early");
    take_clr_a: assert property (tx_pending_o && tx_take_i |=> !tx_pending_o)
        else $error("pending kept after take");
    pend_rise_a: assert property ($rose(tx_pending_o) |-> $past(dwr))
        else $error("pending without write");
endmodule : sbg_assertions
bind sbg_top sbg_assertions #(.ADDR_W(ADDR_W)) i_sbg_assertions (
    .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .tx_holding_o(tx_holding_o), .tx_pending_o(tx_pending_o),
    .tx_take_i(tx_take_i)
);
`default_nettype wire

// ===== tb/sbg_shift_model.sv
`timescale 1ns/1ps
`default_nettype none
module sbg_shift_model (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 tx_pending,
    input  wire logic                 slow,
    input  wire logic                 rx_go,
    input  wire sbg_pkg::sbg_rx_evt_t rx_want,
    output var logic                  tx_take,
    output var logic                  tx_done,
    output var sbg_pkg::sbg_rx_evt_t  rx_evt
);
    import sbg_pkg::*;
    logic [4:0] cnt = 5'h0;
    initial begin
        tx_take = 1'b0;
        tx_done = 1'b0;
        rx_evt = '0;
    end
    // Shifter takes a waiting byte after a pause, frame ends a cycle later
    always @(posedge clk) begin
        tx_take <= 1'b0;
        tx_done <= tx_take;
        rx_evt <= rx_go ? rx_want : '0;
        if (rst) begin
            cnt <= 5'h0;
        end else if (tx_pending && !tx_take) begin
            cnt <= cnt + 5'h1;
            if (cnt >= (slow ? 5'h14 : 5'h1)) begin
                tx_take <= 1'b1;
                cnt <= 5'h0;
            end
        end
    end
endmodule : sbg_shift_model
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import sbg_pkg::*;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic slow = 1'b0, go = 1'b0, ack, pend, take, done, ttk, rtk;
    logic [11:0] adr = 12'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat;
    logic [7:0] hold, c1, c2, q[$], lf = 8'h1e;
    logic [7:0] pf[4] = '{8'h1, 8'h3, 8'h4, 8'hd};
    logic [7:0] rw[5] = '{IDX_BAUD, IDX_CTRL_ONE, IDX_CTRL_TWO,
        IDX_RX_FINE, IDX_TX_FINE};
    sbg_rx_evt_t want = '0, evt;
    int n_mismatch = 0, n_compared = 0, i;
    always #10 clk = ~clk;
    sbg_top i_sbg_top (
        .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .tx_holding_o(hold),
        .tx_pending_o(pend), .tx_take_i(take), .tx_done_i(done),
        .rx_evt_i(evt), .ctrl_one_o(c1), .ctrl_two_o(c2),
        .tx_rate_tick_o(ttk), .rx_rate_tick_o(rtk)
    );
    sbg_shift_model i_sbg_shift_model (
        .clk(clk), .rst(rst), .tx_pending(pend), .slow(slow),
        .rx_go(go), .rx_want(want), .tx_take(take), .tx_done(done),
        .rx_evt(evt)
    );
    ////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction : lfsr
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    task end_sim;
        $display("mismatches %0d compares %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim
    // Classic single bus cycle, held until ack
    task bus(input logic w, input logic [7:0] x, input logic [7:0] d,
        input logic s);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {2'h0, x, 2'h0};
        sel <= {3'h0, s};
        wdat <= {24'h0, d};
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus
    task wr(input logic [7:0] x, input logic [7:0] d);
        bus(1'b1, x, d, 1'b1);
    endtask : wr
    task rd(input logic [7:0] x, input logic [7:0] e);
        q.push_back(e);
        bus(1'b0, x, 8'h0, 1'b1);
    endtask : rd
    task push(input sbg_rx_evt_t e);
        @(posedge clk);
        want <= e;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : push
    // Settle two ticks, then count one period
    task per(input logic r, input logic [31:0] e);
        int n;
        repeat (2) begin
            @(posedge clk);
            while ((r ? rtk : ttk) !== 1'b1) @(posedge clk);
        end
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((r ? rtk : ttk) !== 1'b1);
        chk(32'(n), e);
    endtask : per
    ////////////////////////////////////////////////////////////////////
    // Read answers against the oldest expectation
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0) begin
            chk(rdat, {24'h0, q.pop_front()});
        end
    end
    // Cut a hang short
    initial begin
        #1_000_000;
        n_mismatch++;
        end_sim();
    end
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(IDX_STATUS, STATUS_RST);
        rd(IDX_TX_FINE, 8'h00);
        wr(8'h56, 8'hff);
        rd(8'h56, 8'h00);
        for (i = 0; i < 5; i++) begin
            lf = lfsr(lf);
            wr(rw[i], lf);
            bus(1'b1, rw[i], ~lf, 1'b0);
            rd(rw[i], lf);
        end
        wr(IDX_CTRL_ONE, 8'h5a);
        wr(IDX_CTRL_TWO, 8'ha5);
        chk({16'h0, c1, c2}, 32'h5aa5);
        wr(IDX_TX_FINE, 8'h00);
        wr(IDX_RX_FINE, 8'h00);
        for (i = 0; i < 4; i++) begin
            wr(IDX_BAUD, {i[1:0], 3'(i + 1), 3'(i)});
            per(1'b0, 32'(pf[i]) << (i + 1));
            per(1'b1, 32'(pf[i]) << i);
        end
        wr(IDX_BAUD, 8'h7f);
        wr(IDX_TX_FINE, 8'h02);
        wr(IDX_RX_FINE, 8'h01);
        per(1'b0, 32'h60);
        per(1'b1, 32'h30);
        wr(IDX_BAUD, 8'h3f);
        wr(IDX_TX_FINE, 8'h00);
        wr(IDX_RX_FINE, 8'hff);
        per(1'b0, 32'h80);
        per(1'b1, 32'hff0);
        rd(IDX_STATUS, 8'hc0);
        rd(IDX_DATA, 8'h00);
        wr(IDX_DATA, 8'h5a);
        @(posedge clk);
        chk({23'h0, hold, pend}, {23'h0, 8'h5a, 1'b0});
        for (i = 0; i < 2; i++) begin
            slow <= (i == 0);
            lf = lfsr(lf);
            rd(IDX_STATUS, 8'hc0);
            wr(IDX_DATA, lf);
            chk({23'h0, hold, pend}, {23'h0, lf, 1'b1});
            if (i == 0) begin
                rd(IDX_STATUS, 8'h00);
            end
            while (pend !== 1'b0) @(posedge clk);
            repeat (3) @(posedge clk);
        end
        push('{1'b1, 1'b1, 1'b1, 1'b1, 8'h3c});
        rd(IDX_STATUS, 8'hf6);
        rd(IDX_DATA, 8'h3c);
        rd(IDX_STATUS, 8'hc0);
        push('{1'b1, 1'b0, 1'b0, 1'b0, 8'h81});
        push('{1'b1, 1'b0, 1'b0, 1'b0, 8'h7e});
        rd(IDX_STATUS, 8'he8);
        rd(IDX_DATA, 8'h81);
        rd(IDX_STATUS, 8'hc0);
        wr(IDX_BAUD, 8'hc0);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(IDX_RX_FINE, 8'h00);
        wr(IDX_TX_FINE, 8'h01);
        per(1'b0, 32'h10);
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
